// ---- rtl/ssb_sram_ctrl.sv ----
// synchronous sram core with burst counter, output mode strap and sleep control
`timescale 1ns/1ps
`include "ssb_cfg.svh"

module ssb_sram_ctrl #(
	parameter int ADDR_W = `SSB_ADDR_W,
	parameter int DATA_W = `SSB_DATA_W,
	parameter int NBYTES = `SSB_BYTES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// memory bus from the controller
	input wire logic CKE_N,
	input wire logic E1_N,
	input wire logic E2,
	input wire logic E3_N,
	input wire logic ADVANCE_LOAD,
	input wire logic W_N,
	input wire logic [NBYTES-1:0] BYTE_WRITE_STROBES_N,
	input wire logic [ADDR_W-1:0] A,
	// data pins
	input wire logic [DATA_W-1:0] DQ,
	output logic [DATA_W-1:0] DQ_DRV,
	output logic DQ_OE,
	// straps and sleep
	input wire logic BURST_ORDER_SELECT,
	input wire logic OUTPUT_REGISTER_SELECT_N,
	input wire logic SLEEP_REQUEST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`SSB_PADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);

	localparam int BW = DATA_W / NBYTES;
	localparam int ENT = `SSB_SLEEP_ENTRY_CYC;

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// sleep latency is the synchroniser depth, so entry and exit each cost
	// exactly the documented cycles
	logic [ENT-1:0] zz_sync_r;
	logic [1:0] ft_sync_r;
	logic [1:0] lbo_sync_r;
	logic sleeping;
	logic pipelined;
	logic interleaved;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			zz_sync_r <= '0;
			ft_sync_r <= `SSB_FT_STRAP_RST;
			lbo_sync_r <= `SSB_LBO_STRAP_RST;
		end else begin
			zz_sync_r <= {zz_sync_r[ENT-2:0], SLEEP_REQUEST};
			ft_sync_r <= {ft_sync_r[0], OUTPUT_REGISTER_SELECT_N};
			lbo_sync_r <= {lbo_sync_r[0], BURST_ORDER_SELECT};
		end
	end

	assign sleeping = zz_sync_r[ENT-1];
	assign pipelined = ft_sync_r[1];
	assign interleaved = lbo_sync_r[1];

	// ----------------------------------------------------------------
	// sleep recovery window
	// ----------------------------------------------------------------
	logic sleeping_q_r;
	logic [`SSB_RECOV_W-1:0] recov_r;
	logic recovering;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sleeping_q_r <= 1'b0;
			recov_r <= '0;
		end else begin
			sleeping_q_r <= sleeping;
			if (sleeping_q_r && !sleeping) begin
				recov_r <= `SSB_RECOV_W'(`SSB_SLEEP_RECOV_CYC - 1);
			end else if (recov_r != '0) begin
				recov_r <= recov_r - `SSB_RECOV_W'(1);
			end
		end
	end

	// the wake cycle itself is the first recovery cycle
	assign recovering = (recov_r != '0) || (sleeping_q_r && !sleeping);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic active;
	logic selected;
	logic load;
	logic advance_load;
	logic wr_cmd;
	logic wr_now;
	logic rd_now;
	logic ctrl_block_r;
	ssb_pkg::ssb_kind_t kind_r;
	ssb_pkg::ssb_kind_t kind_nxt;

	// hold and sleep both stop every clocked memory-side update below; the apb registers still update
	assign active = !CKE_N && !sleeping;
	assign selected = !E1_N && E2 && !E3_N;
	assign load = active && !ADVANCE_LOAD;
	assign advance_load = active && ADVANCE_LOAD;

	always_comb begin
		kind_nxt = kind_r;
		if (load) begin
			if (!selected) begin
				kind_nxt = ssb_pkg::SSB_IDLE;
			end else if (W_N) begin
				kind_nxt = ssb_pkg::SSB_RD;
			end else begin
				kind_nxt = ssb_pkg::SSB_WR;
			end
		end
	end

	// continue cycles inherit the kind of the burst that was loaded
	assign rd_now = active && (kind_nxt == ssb_pkg::SSB_RD);
	assign wr_cmd = active && (kind_nxt == ssb_pkg::SSB_WR);
	// optional guard: drop writes that break the recovery window
	assign wr_now = wr_cmd && !(recovering && ctrl_block_r);

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			kind_r <= ssb_pkg::SSB_IDLE;
		end else if (active) begin
			kind_r <= kind_nxt;
		end
	end

	// ----------------------------------------------------------------
	// burst address
	// ----------------------------------------------------------------
	logic [`SSB_BURST_W-1:0] addr_lo;
	logic [ADDR_W-1:`SSB_BURST_W] hi_r;
	logic [ADDR_W-1:0] eff_addr;

	ssb_burst_ctr #(
		.W(`SSB_BURST_W)
	) u_burst (
		.clk(CLK),
		.rst(SYS_RST),
		.load(load),
		.advance(advance_load),
		.interleave(interleaved),
		.start(A[`SSB_BURST_W-1:0]),
		.addr_lo(addr_lo)
	);

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			hi_r <= '0;
		end else if (load) begin
			hi_r <= A[ADDR_W-1:`SSB_BURST_W];
		end
	end

	assign eff_addr = load ? A : {hi_r, addr_lo};

	property p_high_bits;
		@(posedge CLK) disable iff (SYS_RST)
		load ##1 (advance_load[*3]) |-> eff_addr[ADDR_W-1:`SSB_BURST_W] == $past(A[ADDR_W-1:`SSB_BURST_W], 3);
	endproperty
	a_high_bits: assert property (p_high_bits) else $error("upper address drifted in burst");

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic rdp_valid_r;
	logic [DATA_W-1:0] rdp_data_r;
	logic oe_r;
	logic [DATA_W-1:0] dq_r;

	// flow-through loads the output flop at the command edge, pipelined
	// takes one more stage; both leave DQ_DRV straight from a flop
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rdp_valid_r <= 1'b0;
			rdp_data_r <= '0;
			oe_r <= 1'b0;
			dq_r <= '0;
		end else if (active) begin
			rdp_valid_r <= rd_now;
			rdp_data_r <= mem[eff_addr];
			oe_r <= pipelined ? rdp_valid_r : rd_now;
			dq_r <= pipelined ? rdp_data_r : mem[eff_addr];
		end
	end

	assign DQ_DRV = dq_r;
	assign DQ_OE = oe_r && !sleeping;

	property p_flow_read;
		@(posedge CLK) disable iff (SYS_RST)
		(rd_now && !pipelined) |=> (DQ_OE || sleeping);
	endproperty
	a_flow_read: assert property (p_flow_read) else $error("flow-through read not driven");

	property p_pipe_read;
		@(posedge CLK) disable iff (SYS_RST)
		(rd_now && pipelined) ##1 (active && pipelined) |=> (DQ_OE || sleeping);
	endproperty
	a_pipe_read: assert property (p_pipe_read) else $error("pipelined read not driven");

	// ----------------------------------------------------------------
	// late write path
	// ----------------------------------------------------------------
	ssb_pkg::ssb_wctl_t w1_r;
	ssb_pkg::ssb_wctl_t w2_r;
	ssb_pkg::ssb_wctl_t wsel;
	logic mem_we;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			w1_r <= '0;
			w2_r <= '0;
		end else if (active) begin
			w1_r <= '{valid: wr_now, bw_n: BYTE_WRITE_STROBES_N, addr: eff_addr};
			w2_r <= w1_r;
		end
	end

	// single late write in flow-through, double late in pipelined
	assign wsel = pipelined ? w2_r : w1_r;
	assign mem_we = active && wsel.valid && !(&wsel.bw_n);

	always_ff @(posedge CLK) begin
		if (mem_we) begin
			for (int b = 0; b < NBYTES; b++) begin
				if (!wsel.bw_n[b]) begin
					mem[wsel.addr][b*BW +: BW] <= DQ[b*BW +: BW];
				end
			end
		end
	end

	property p_pipe_write;
		@(posedge CLK) disable iff (SYS_RST)
		(wr_now && pipelined) ##1 (active && pipelined)[*2]
			|-> mem_we == !(&$past(BYTE_WRITE_STROBES_N, 2));
	endproperty
	a_pipe_write: assert property (p_pipe_write) else $error("pipelined write at wrong edge");

	property p_flow_write;
		@(posedge CLK) disable iff (SYS_RST)
		(wr_now && !pipelined) ##1 (active && !pipelined)
			|-> mem_we == !(&$past(BYTE_WRITE_STROBES_N));
	endproperty
	a_flow_write: assert property (p_flow_write) else $error("flow-through write at wrong edge");

	property p_hold_freeze;
		@(posedge CLK) disable iff (SYS_RST)
		(CKE_N && !sleeping) |=> ($stable(kind_r) && $stable(dq_r) && $stable(oe_r) && $stable(w1_r));
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("state moved under hold");

	// ----------------------------------------------------------------
	// sleep checks
	// ----------------------------------------------------------------
	property p_sleep_entry;
		@(posedge CLK) disable iff (SYS_RST)
		SLEEP_REQUEST[*2] |=> sleeping;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered in two cycles");

	property p_sleep_exit;
		@(posedge CLK) disable iff (SYS_RST)
		(!SLEEP_REQUEST)[*2] |=> !sleeping;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left in two cycles");

	property p_sleep_quiet;
		@(posedge CLK) disable iff (SYS_RST)
		sleeping |-> (!DQ_OE && !mem_we && (!$past(sleeping) || $stable(hi_r)));
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity while asleep");

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	logic hit_status;
	logic hit_ctrl;
	logic apb_wr;
	logic viol_r;
	logic [31:0] status_vec;
	logic [31:0] ctrl_vec;
	logic [31:0] prdata_r;

	assign hit_status = (PADDR == `SSB_OFF_STATUS);
	assign hit_ctrl = (PADDR == `SSB_OFF_CTRL);
	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit_status && !hit_ctrl;

	always_comb begin
		status_vec = '0;
		status_vec[`SSB_ST_SLEEP_BIT] = sleeping;
		status_vec[`SSB_ST_RECOV_BIT] = recovering;
		status_vec[`SSB_ST_PIPE_BIT] = pipelined;
		status_vec[`SSB_ST_ILV_BIT] = interleaved;
		status_vec[`SSB_ST_VIOL_BIT] = viol_r;
		status_vec[`SSB_ST_BURST_BIT] = (kind_r != ssb_pkg::SSB_IDLE);
		ctrl_vec = '0;
		ctrl_vec[`SSB_CTRL_BLOCK_BIT] = ctrl_block_r;
	end

	// read data is captured in the setup phase so PRDATA is a flop
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			prdata_r <= '0;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			prdata_r <= hit_status ? status_vec : (hit_ctrl ? ctrl_vec : '0);
		end
	end

	assign PRDATA = prdata_r;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_block_r <= `SSB_CTRL_BLOCK_RST;
		end else if (apb_wr && hit_ctrl) begin
			ctrl_block_r <= PWDATA[`SSB_CTRL_BLOCK_BIT];
		end
	end

	// a new violation in the clearing cycle survives the clear
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			viol_r <= 1'b0;
		end else begin
			viol_r <= (wr_cmd && recovering) ||
				(viol_r && !(apb_wr && hit_status && PWDATA[`SSB_ST_VIOL_BIT]));
		end
	end

	property p_recov_flag;
		@(posedge CLK) disable iff (SYS_RST)
		(wr_cmd && recovering) |=> viol_r;
	endproperty
	a_recov_flag: assert property (p_recov_flag) else $error("recovery write not flagged");

endmodule : ssb_sram_ctrl

// ---- pkg/ssb_cfg.svh ----
// named constants for the synchronous sram burst and sleep control block
`ifndef SSB_CFG_SVH
`define SSB_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SSB_ADDR_W 10
`define SSB_DATA_W 32
`define SSB_BYTES 4
`define SSB_BURST_W 2
`define SSB_PADDR_W 8

// ----------------------------------------------------------------
// sleep timing, in clock cycles, and the recovery counter width in bits
// ----------------------------------------------------------------
`define SSB_SLEEP_ENTRY_CYC 2
`define SSB_SLEEP_RECOV_CYC 2
`define SSB_RECOV_W 2

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SSB_OFF_STATUS 8'h00
`define SSB_OFF_CTRL 8'h04
`define SSB_ST_SLEEP_BIT 0
`define SSB_ST_RECOV_BIT 1
`define SSB_ST_PIPE_BIT 2
`define SSB_ST_ILV_BIT 3
`define SSB_ST_VIOL_BIT 4
`define SSB_ST_BURST_BIT 5
`define SSB_CTRL_BLOCK_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSB_CTRL_BLOCK_RST 1'b0
`define SSB_FT_STRAP_RST 2'h3
`define SSB_LBO_STRAP_RST 2'h0

`endif

// ---- pkg/ssb_pkg.sv ----
// types shared by the sram burst and sleep control block
`include "ssb_cfg.svh"

package ssb_pkg;

	typedef enum logic [2:0] {
		SSB_IDLE = 3'b001,
		SSB_RD = 3'b010,
		SSB_WR = 3'b100
	} ssb_kind_t;

	typedef struct packed {
		logic valid;
		logic [`SSB_BYTES-1:0] bw_n;
		logic [`SSB_ADDR_W-1:0] addr;
	} ssb_wctl_t;

endpackage : ssb_pkg

// ---- rtl/ssb_burst_ctr.sv ----
// two-bit burst address generator, linear or interleaved order
`timescale 1ns/1ps
`include "ssb_cfg.svh"

module ssb_burst_ctr #(
	parameter int W = `SSB_BURST_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// command
	input wire logic load,
	input wire logic advance,
	input wire logic interleave,
	input wire logic [W-1:0] start,
	// address low bits of this access
	output logic [W-1:0] addr_lo
);

	logic [W-1:0] start_r;
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	assign cnt_nxt = cnt_r + W'(1);

	// seed taken on load, counter steps on every continue
	always_comb begin
		if (load) begin
			addr_lo = start;
		end else if (interleave) begin
			addr_lo = start_r ^ cnt_nxt;
		end else begin
			addr_lo = start_r + cnt_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			start_r <= '0;
			cnt_r <= '0;
		end else if (load) begin
			start_r <= start;
			cnt_r <= '0;
		end else if (advance) begin
			cnt_r <= cnt_nxt;
		end
	end

	property p_wrap_four;
		@(posedge clk) disable iff (rst)
		load ##1 (advance && !load)[*4] |-> addr_lo == $past(start, 4);
	endproperty
	a_wrap_four: assert property (p_wrap_four) else $error("burst did not wrap after four");

	property p_linear_step;
		@(posedge clk) disable iff (rst)
		(load && !interleave) ##1 (advance && !interleave) |-> addr_lo == $past(start) + W'(1);
	endproperty
	a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

	property p_ilv_step;
		@(posedge clk) disable iff (rst)
		(load && interleave) ##1 (advance && interleave) |-> addr_lo == ($past(start) ^ W'(1));
	endproperty
	a_ilv_step: assert property (p_ilv_step) else $error("interleaved step wrong");

endmodule : ssb_burst_ctr

// ---- dv/ssb_mem_host.sv ----
// controller side of the data bus: late write data and bus resolution
`timescale 1ns/1ps

module ssb_mem_host (
	// clock and command
	input wire logic clk,
	input wire logic cke_n,
	input wire logic pipe,
	input wire logic wr,
	input wire logic [31:0] wd,
	// device side of the bus
	input wire logic dq_oe,
	input wire logic [31:0] dq_drv,
	output logic [31:0] dq
);
	logic [32:0] st1_r = 33'h0;
	logic [32:0] st2_r = 33'h0;
	logic [31:0] last_r = 32'h0;
	logic [32:0] cur;

	// write data trails its command by one or two active edges
	always @(posedge clk) begin
		if (!cke_n) begin
			st1_r <= {wr, wd};
			st2_r <= st1_r;
		end
		last_r <= dq;
	end
	assign cur = pipe ? st2_r : st1_r;

	// released bus flips each cycle so a stale value never looks valid
	always_comb begin
		if (dq_oe)
			dq = dq_drv;
		else if (cur[32])
			dq = cur[31:0];
		else
			dq = ~last_r;
	end
endmodule : ssb_mem_host

// ---- dv/ssb_sram_ctrl_tb.sv ----
// self-checking bench for the sram burst and sleep control block
`timescale 1ns/1ps
`include "ssb_cfg.svh"

module ssb_sram_ctrl_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cke_n = 1'b0;
	logic e1_n = 1'b1;
	logic advance_load = 1'b0;
	logic w_n = 1'b1;
	logic [3:0] bw_n = 4'hF;
	logic [9:0] a = 10'h000;
	logic [31:0] wd = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] dq, dq_drv, prdata, rd;
	logic burst_order_select = 1'b0;
	logic ft_n = 1'b1;
	logic zz = 1'b0;
	logic wr = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic dq_oe, pready, pslverr, err;
	logic kind_w = 1'b0;
	logic [31:0] dq_s = 32'h0;
	logic oe_s = 1'b0;
	int error_cnt = 0;
	int num_checks = 0;

	always #20 clk = ~clk;

	// settled outputs, so checks right after an edge never race the design
	always @(negedge clk) begin
		dq_s <= dq_drv;
		oe_s <= dq_oe;
	end

	ssb_sram_ctrl dut (.CLK(clk), .SYS_RST(rst), .CKE_N(cke_n), .E1_N(e1_n), .E2(1'b1),
		.E3_N(1'b0), .ADVANCE_LOAD(advance_load), .W_N(w_n), .BYTE_WRITE_STROBES_N(bw_n), .A(a),
		.DQ(dq), .DQ_DRV(dq_drv), .DQ_OE(dq_oe), .BURST_ORDER_SELECT(burst_order_select),
		.OUTPUT_REGISTER_SELECT_N(ft_n), .SLEEP_REQUEST(zz), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr));

	ssb_mem_host host (.clk(clk), .cke_n(cke_n), .pipe(ft_n), .wr(wr), .wd(wd),
		.dq_oe(dq_oe), .dq_drv(dq_drv), .dq(dq));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] pat(input logic [9:0] x);
		return 32'hC3000000 ^ {22'h0, x} ^ {x, 22'h0};
	endfunction : pat

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic op(input logic l, input logic wn, input logic [3:0] b,
		input logic [9:0] ad, input logic [31:0] d);
		if (!l)
			kind_w = ~wn;
		e1_n <= 1'b0;
		advance_load <= l;
		w_n <= wn;
		bw_n <= b;
		a <= ad;
		wd <= d;
		wr <= kind_w;
		@(posedge clk);
	endtask : op

	task automatic idle(input int n);
		kind_w = 1'b0;
		e1_n <= 1'b1;
		advance_load <= 1'b0;
		wr <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle

	// one edge always passes first, so strobes are never re-driven in one step
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic rd1(input logic [9:0] ad, input int lat, input logic [31:0] exp);
		op(1'b0, 1'b1, 4'hF, ad, 32'h0);
		idle(lat);
		chk(dq_s, exp);
	endtask : rd1

	// continues drive a wrong address: only the counter may matter
	task automatic rdburst(input logic [9:0] s, input logic ilv, input int lat);
		logic [9:0] ad;
		for (int i = 0; i < 5 + lat; i++) begin
			if (i < 5)
				op(i > 0, 1'b1, 4'hF, (i > 0) ? ~s : s, 32'h0);
			else
				idle(1);
			if (i >= lat) begin
				ad = {s[9:2], ilv ? s[1:0] ^ 2'(i - lat) : s[1:0] + 2'(i - lat)};
				chk(32'(oe_s), 32'h1);
				chk(dq_s, pat(ad));
			end
		end
	endtask : rdburst

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, `SSB_OFF_STATUS, 32'h0);
		chk(rd & 32'h0000001F, 32'h00000004);
		apb(1'b0, 8'h08, 32'h0);
		chk({rd[30:0], err}, 32'h00000001);
		apb(1'b1, `SSB_OFF_CTRL, 32'h00000001);
		apb(1'b0, `SSB_OFF_CTRL, 32'h0);
		chk(rd, 32'h00000001);
		$display("done: registers");
	endtask : t_regs

	task automatic t_pipe();
		for (int i = 0; i < 8; i++)
			op(1'b0, 1'b0, 4'h0, 10'h040 + 10'(i), pat(10'h040 + 10'(i)));
		for (int o = 0; o < 2; o++) begin
			burst_order_select <= o[0];
			idle(3);
			for (int s = 0; s < 4; s++)
				rdburst(10'h040 + 10'(s), o[0], 2);
		end
		burst_order_select <= 1'b0;
		idle(3);
		$display("done: pipelined bursts");
	endtask : t_pipe

	task automatic t_hold();
		op(1'b0, 1'b1, 4'hF, 10'h041, 32'h0);
		op(1'b1, 1'b1, 4'hF, 10'h000, 32'h0);
		cke_n <= 1'b1;
		repeat (3) begin
			@(posedge clk);
			chk(dq_s, pat(10'h041));
		end
		cke_n <= 1'b0;
		op(1'b1, 1'b1, 4'hF, 10'h000, 32'h0);
		idle(1);
		chk(dq_s, pat(10'h042));
		idle(1);
		chk(dq_s, pat(10'h043));
		$display("done: clock hold");
	endtask : t_hold

	task automatic t_bytes();
		op(1'b0, 1'b0, 4'hE, 10'h045, 32'hFFFFFFFF);
		op(1'b0, 1'b0, 4'hF, 10'h046, 32'h00000000);
		idle(3);
		rd1(10'h045, 2, pat(10'h045) | 32'h000000FF);
		rd1(10'h046, 2, pat(10'h046));
		$display("done: byte strobes");
	endtask : t_bytes

	// recovery write is a deliberate misuse; the drop bit is set
	task automatic t_sleep();
		idle(2);
		zz <= 1'b1;
		apb(1'b0, `SSB_OFF_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h0);
		apb(1'b0, `SSB_OFF_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h1);
		op(1'b0, 1'b0, 4'h0, 10'h041, 32'h0);
		chk(32'(oe_s), 32'h0);
		idle(4);
		zz <= 1'b0;
		idle(2);
		op(1'b0, 1'b0, 4'h0, 10'h042, 32'h0);
		idle(4);
		apb(1'b0, `SSB_OFF_STATUS, 32'h0);
		chk(rd & 32'h17, 32'h14);
		apb(1'b1, `SSB_OFF_STATUS, 32'h10);
		apb(1'b0, `SSB_OFF_STATUS, 32'h0);
		chk(rd & 32'h10, 32'h0);
		rd1(10'h041, 2, pat(10'h041));
		rd1(10'h042, 2, pat(10'h042));
		apb(1'b1, `SSB_OFF_CTRL, 32'h0);
		$display("done: sleep");
	endtask : t_sleep

	task automatic t_flow();
		ft_n <= 1'b0;
		idle(3);
		apb(1'b0, `SSB_OFF_STATUS, 32'h0);
		chk(rd & 32'h4, 32'h0);
		for (int i = 0; i < 4; i++)
			op(1'b0, 1'b0, 4'h0, 10'h080 + 10'(i), pat(10'h080 + 10'(i)));
		rdburst(10'h040, 1'b0, 1);
		rdburst(10'h082, 1'b0, 1);
		$display("done: flow-through");
	endtask : t_flow

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		idle(2);
		t_regs();
		t_pipe();
		t_hold();
		t_bytes();
		t_sleep();
		t_flow();
		stop_test();
	end

	// run needs well under a thousand cycles
	initial begin
		#400000;
		error_cnt++;
		stop_test();
	end
endmodule : ssb_sram_ctrl_tb
